/* File: src/iodi_cpu.sv */
`timescale 1ns/10ps
`default_nettype none

module iodi_cpu (
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    iodi_if.cpu                                bus,
    input  wire logic                          cmd_valid,
    input  wire iodi_pkg::iodi_kind_t          cmd_kind,
    input  wire logic [iodi_pkg::CODE_W-1:0]   cmd_code,
    input  wire logic [iodi_pkg::DATA_W-1:0]   cmd_wdata,
    output logic                               cmd_ready_q,
    output logic                               rsp_valid_q,
    output logic [iodi_pkg::DATA_W-1:0]        rsp_data_q,
    output logic                               rsp_busy_q,
    output logic                               rsp_done_q
);
    import iodi_pkg::*;

    // ========================================
    // Elaboration checks
    if (IN_PULSE_CYC >= (1 << CNT_W)) begin : g_bad_cnt
        $error("Strobe width overflows the counter.");
    end

    // ========================================
    // Registers
    iodi_state_t       state_q;    // Sequencer state.
    logic [CNT_W-1:0]  cnt_q;      // Cycles left in the strobe.
    logic [6:0]        strobe_q;   // One-hot strobe outputs.
    logic [6:0]        strobe_d;   // Strobe for the new command.
    logic              oe_q;       // Data line enable.
    logic [DATA_W-1:0] wdata_q;    // Word driven for the mask.
    logic [CODE_W-1:0] code_q;     // Device code on select lines.
    logic [CNT_W-1:0]  len_d;      // Strobe length minus one.

    wire take = (state_q == IODI_IDLE) && cmd_valid;

    // Strobe bit and width per operation.
    always_comb begin
        strobe_d = 7'h00;
        len_d    = CNT_W'(IN_PULSE_CYC - 1);
        case (cmd_kind)
            IODI_RD_FIRST:  strobe_d = 7'h01;
            IODI_RD_SECOND: strobe_d = 7'h02;
            IODI_RD_THIRD:  strobe_d = 7'h04;
            IODI_MASK: begin
                strobe_d = 7'h08;
                len_d    = CNT_W'(OUT_PULSE_CYC - 1);
            end
            IODI_INT_ACK:   strobe_d = 7'h10;
            IODI_CH_ADDR:   strobe_d = 7'h20;
            IODI_CH_IN:     strobe_d = 7'h40;
            IODI_TEST:      len_d    = CNT_W'(RESP_CYC - 1);
            default:        strobe_d = 7'h00;
        endcase
    end

    // ========================================
    // Sequencer
    // Idle takes a command, strobe counts its width and samples
    // on its last cycle, fin leaves one cycle with no strobe or processor drive.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q     <= IODI_IDLE;
            cnt_q       <= '0;
            strobe_q    <= 7'h00;
            oe_q        <= 1'b0;
            wdata_q     <= DATA_RST;
            code_q      <= CODE_RST;
            cmd_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= DATA_RST;
            rsp_busy_q  <= 1'b0;
            rsp_done_q  <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                IODI_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    if (take) begin
                        state_q     <= IODI_STROBE;
                        cmd_ready_q <= 1'b0;
                        cnt_q       <= len_d;
                        strobe_q    <= strobe_d;
                        code_q      <= cmd_code;
                        wdata_q     <= cmd_wdata;
                        oe_q        <= (cmd_kind == IODI_MASK);
                    end
                end
                IODI_STROBE: begin
                    if (cnt_q == '0) begin
                        state_q     <= IODI_FIN;
                        strobe_q    <= 7'h00;
                        oe_q        <= 1'b0;
                        rsp_valid_q <= 1'b1;
                        rsp_data_q  <= bus.data_bus;
                        rsp_busy_q  <= ~bus.selected_busy_line_n;
                        rsp_done_q  <= ~bus.selected_done_line_n;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                IODI_FIN: begin
                    state_q     <= IODI_IDLE;
                    cmd_ready_q <= 1'b1;
                end
                default: state_q <= IODI_IDLE;
            endcase
        end
    end

    // ========================================
    // Bus outputs, straight from the registers
    assign bus.device_select_code    = code_q;
    assign bus.read_strobe_first     = strobe_q[0];
    assign bus.read_strobe_second    = strobe_q[1];
    assign bus.read_strobe_third     = strobe_q[2];
    assign bus.mask_load_strobe      = strobe_q[3];
    assign bus.interrupt_ack_cycle   = strobe_q[4];
    assign bus.channel_address_cycle = strobe_q[5];
    assign bus.channel_input_cycle   = strobe_q[6];
    assign bus.data_from_cpu         = wdata_q;
    assign bus.data_cpu_oe           = oe_q;

endmodule : iodi_cpu

`default_nettype wire

/* File: src/iodi_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none

module iodi_ctrl #(
    parameter logic [5:0] DEV_CODE = 6'h10,  // This controller's code.
    parameter int         MASK_BIT = 0       // Data line of its mask bit.
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    iodi_if.dev                            bus,
    input  wire logic [iodi_pkg::DATA_W-1:0] reg_first,
    input  wire logic [iodi_pkg::DATA_W-1:0] reg_second,
    input  wire logic [iodi_pkg::DATA_W-1:0] reg_third,
    input  wire logic                      busy_flag,
    input  wire logic                      done_flag,
    input  wire logic                      int_pending,
    input  wire logic                      chan_grant,
    input  wire logic [iodi_pkg::DATA_W-1:0] chan_addr,
    input  wire logic [iodi_pkg::DATA_W-1:0] chan_data,
    output logic                           int_mask_q,
    output logic                           read_pulse_q,
    output logic [1:0]                     read_which_q
);
    import iodi_pkg::*;

    // ========================================
    // Elaboration checks
    if (MASK_BIT < 0 || MASK_BIT >= DATA_W) begin : g_bad_mask
        $error("Mask bit lies outside the data lines.");
    end

    // The acknowledge word pads the code, so it must fit.
    if (DATA_W <= CODE_W) begin : g_bad_width
        $error("Data lines narrower than the device code.");
    end

    // ========================================
    // Registers
    // Everything that meets the bus is registered, so
    // decode glitches never reach the shared lines.
    logic [DATA_W-1:0] data_q;       // Word on the data lines.
    logic [DATA_W-1:0] data_d;       // Next word.
    logic              oe_q;         // Data line enable.
    logic              oe_d;         // Next enable.
    logic              busy_q;       // Busy line pull.
    logic              done_q;       // Done line pull.
    logic              mask_d;       // Next mask bit.
    logic              in_any_q;     // A data-in was active last cycle.
    logic [1:0]        which_d;      // Which data-in strobe is active.

    // ========================================
    // Decode
    // The select lines carry junk outside I/O instructions, so a
    // data-in strobe gates the match; only busy and done follow it alone.
    wire code_hit = (bus.device_select_code == DEV_CODE);

    // A bare match would fight the real source when a
    // non-I/O instruction leaves junk on the select lines.
    // Data-in strobes qualified by the select match.
    wire in_first  = code_hit & bus.read_strobe_first;
    wire in_second = code_hit & bus.read_strobe_second;
    wire in_third  = code_hit & bus.read_strobe_third;
    wire in_any    = in_first | in_second | in_third;

    // Acknowledge answers only while an interrupt is pending.
    // No priority chain is modelled, so the user side must
    // raise int_pending on one controller only.
    wire ack_src   = bus.interrupt_ack_cycle & int_pending;

    // Channel cycles answer only when this controller won the grant.
    // The grant alone qualifies them, not the code.
    // Two granted controllers would fight on the lines.
    wire addr_src  = bus.channel_address_cycle & chan_grant;
    wire chin_src  = bus.channel_input_cycle & chan_grant;

    // Mask word is sampled by every controller on its own line.
    // It is a broadcast, so no select match is needed.
    wire mask_take = bus.mask_load_strobe;

    // The device code padded onto the data lines for acknowledge.
    // It tells the processor which controller answered.
    wire [DATA_W-1:0] ack_word = {{(DATA_W - CODE_W){1'b0}}, DEV_CODE};

    // ========================================
    // Source selection
    // Only one source cycle is active at a time on a sane bus; the
    // data-in strobes win if the processor ever overlaps them.
    // The zero default keeps the word quiet between cycles.
    always_comb begin
        data_d = DATA_RST;
        if (in_first) begin
            data_d = reg_first;
        end else if (in_second) begin
            data_d = reg_second;
        end else if (in_third) begin
            data_d = reg_third;
        end else if (ack_src) begin
            data_d = ack_word;
        end else if (addr_src) begin
            data_d = chan_addr;
        end else if (chin_src) begin
            data_d = chan_data;
        end
    end

    // Drivers open only while this controller is the source.
    // An enable that outlived its strobe would clash with
    // the processor's mask drive in a later instruction.
    assign oe_d = in_any | ack_src | addr_src | chin_src;

    // Report which register was read, in strobe order.
    // Used only under a data-in strobe, so the fall-through
    // to the third index is harmless.
    assign which_d = in_first ? 2'h0 : (in_second ? 2'h1 : 2'h2);

    // Mask bit follows the lines while the strobe stands.
    // Each controller owns the one line MASK_BIT names.
    // Outside the strobe the bit holds its value.
    assign mask_d = mask_take ? bus.data_bus[MASK_BIT] : int_mask_q;

    // ========================================
    // Data line driver
    // Word and enable are registered, so the lines follow the
    // strobe by one clock; strobes far exceed that delay.
    // Reset drops the enable at once, not at a clock, so
    // no controller drives the lines through a reset.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_q <= DATA_RST;
            oe_q   <= 1'b0;
        end else begin
            data_q <= data_d;
            oe_q   <= oe_d;
        end
    end

    // The interface merges these with the processor drive.
    assign bus.data_from_dev = data_q;
    assign bus.data_dev_oe   = oe_q;

    // ========================================
    // Busy and done test lines
    // The test needs no strobe: the processor reads these lines
    // while the code stands, so they follow the match alone.
    // A flag change shows one clock late, well inside
    // the time the processor allows for the answer.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            busy_q <= code_hit & busy_flag;
            done_q <= code_hit & done_flag;
        end
    end

    // High pulls the open-drain line low.
    assign bus.busy_pull = busy_q;
    assign bus.done_pull = done_q;

    // ========================================
    // Mask bit
    // Holds the interrupt disable bit for this controller.
    // A set bit tells the user side to hold its request.
    // Reset clears it, so every controller starts unmasked.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            int_mask_q <= 1'b0;
        end else begin
            int_mask_q <= mask_d;
        end
    end

    // ========================================
    // Read notice to the user side
    // One pulse at the start of each data-in strobe, so the user
    // logic can clear a done flag or advance a pointer.
    // The detector resets to zero, the strobes' idle
    // level, so no false pulse follows reset.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            in_any_q     <= 1'b0;
            read_pulse_q <= 1'b0;
            read_which_q <= 2'h0;
        end else begin
            in_any_q     <= in_any;
            read_pulse_q <= in_any & ~in_any_q;
            // The index stands until the next read starts.
            if (in_any & ~in_any_q) begin
                read_which_q <= which_d;
            end
        end
    end

endmodule : iodi_ctrl

`default_nettype wire

/* File: src/iodi_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface iodi_if;
    import iodi_pkg::*;

    // ========================================
    // Data lines and their two drivers
    logic [DATA_W-1:0] data_from_cpu;         // Value the processor drives.
    logic              data_cpu_oe;           // High while the processor drives.
    logic [DATA_W-1:0] data_from_dev;         // Value the controller drives.
    logic              data_dev_oe;           // High while the controller drives.
    logic [DATA_W-1:0] data_bus;              // Resolved line level.
    // ========================================
    // Select and strobes from the processor
    logic [CODE_W-1:0] device_select_code;    // Addressed device code.
    logic              read_strobe_first;     // First data-in strobe.
    logic              read_strobe_second;    // Second data-in strobe.
    logic              read_strobe_third;     // Third data-in strobe.
    logic              mask_load_strobe;      // Mask word is on the lines.
    logic              interrupt_ack_cycle;   // Interrupt acknowledge.
    logic              channel_address_cycle; // Channel address fetch.
    logic              channel_input_cycle;   // Channel input fetch.
    // ========================================
    // Open-drain test lines, low when pulled
    logic              busy_pull;             // Controller pulls busy line.
    logic              done_pull;             // Controller pulls done line.
    logic              selected_busy_line_n;  // Resolved busy line.
    logic              selected_done_line_n;  // Resolved done line.

    // Resolve the shared lines; released data lines read as zero, released test lines as one.
    assign data_bus = data_cpu_oe ? data_from_cpu :
                      (data_dev_oe ? data_from_dev : DATA_RST);
    assign selected_busy_line_n = ~busy_pull;
    assign selected_done_line_n = ~done_pull;

    modport cpu (
        output data_from_cpu, data_cpu_oe, device_select_code,
        output read_strobe_first, read_strobe_second, read_strobe_third,
        output mask_load_strobe, interrupt_ack_cycle,
        output channel_address_cycle, channel_input_cycle,
        input  data_bus, selected_busy_line_n, selected_done_line_n
    );

    modport dev (
        input  device_select_code, data_bus,
        input  read_strobe_first, read_strobe_second, read_strobe_third,
        input  mask_load_strobe, interrupt_ack_cycle,
        input  channel_address_cycle, channel_input_cycle,
        output data_from_dev, data_dev_oe, busy_pull, done_pull
    );

endinterface : iodi_if

`default_nettype wire

/* File: src/iodi_pkg.sv */
package iodi_pkg;

    // ========================================
    // Bus widths
    localparam int DATA_W = 16;   // Shared data lines.
    localparam int CODE_W = 6;    // Device select lines.
    localparam int CNT_W  = 8;    // Host timing counter.

    // ========================================
    // Timing, in nanoseconds and in cycles of sys_clk
    localparam int CLK_NS       = 8;    // Period of sys_clk.
    localparam int IN_PULSE_NS  = 500;  // Least data-in strobe width.
    localparam int OUT_PULSE_NS = 350;  // Least mask strobe width.
    localparam int RESP_NS      = 150;  // Longest busy/done answer.
    localparam int IN_PULSE_CYC  = (IN_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int OUT_PULSE_CYC = (OUT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESP_CYC      = (RESP_NS + CLK_NS - 1) / CLK_NS;

    // ========================================
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RST = 6'h00;

    // ========================================
    // Host operations
    typedef enum logic [2:0] {
        IODI_RD_FIRST  = 3'b000,  // First data-in instruction.
        IODI_RD_SECOND = 3'b001,  // Second data-in instruction.
        IODI_RD_THIRD  = 3'b010,  // Third data-in instruction.
        IODI_MASK      = 3'b011,  // Mask word broadcast.
        IODI_INT_ACK   = 3'b100,  // Interrupt acknowledge.
        IODI_CH_ADDR   = 3'b101,  // Channel address fetch.
        IODI_CH_IN     = 3'b110,  // Channel input word fetch.
        IODI_TEST      = 3'b111   // Busy and done test.
    } iodi_kind_t;

    // Host sequencer states.
    typedef enum logic [1:0] {
        IODI_IDLE   = 2'b00,
        IODI_STROBE = 2'b01,
        IODI_FIN    = 2'b10
    } iodi_state_t;

endpackage : iodi_pkg

/* File: test/io_bus_data_in_port_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module io_bus_data_in_port_tb_top;
    import iodi_pkg::*;

    // ========================================
    // Stimulus table: command, code, word, enable, expected answer
    typedef struct packed {
        iodi_kind_t        kind;   // Operation of the processor end.
        logic [CODE_W-1:0] code;   // Device code sent.
        logic [DATA_W-1:0] wdata;  // Mask word sent.
        logic              en;     // Drives pending, grant and busy; done gets its inverse.
        logic [DATA_W-1:0] exp;    // Expected word, flags or mask bit.
    } iodi_row_t;

    localparam logic [DATA_W-1:0] W1 = 16'h1234;  // First register.
    localparam logic [DATA_W-1:0] W2 = 16'habcd;  // Second register.
    localparam logic [DATA_W-1:0] W3 = 16'h5a0f;  // Third register.
    localparam logic [DATA_W-1:0] WA = 16'h0c3e;  // Channel address.
    localparam logic [DATA_W-1:0] WD = 16'h7e81;  // Channel data.
    localparam iodi_row_t ROWS [15] = '{
        '{IODI_RD_FIRST, 6'h10, 16'h0, 1'b0, W1}, '{IODI_RD_SECOND, 6'h10, 16'h0, 1'b0, W2},
        '{IODI_RD_THIRD, 6'h10, 16'h0, 1'b0, W3}, '{IODI_RD_SECOND, 6'h11, 16'h0, 1'b0, 16'h0},
        '{IODI_RD_THIRD, 6'h3f, 16'h0, 1'b0, 16'h0}, '{IODI_INT_ACK, 6'h00, 16'h0, 1'b1, 16'h0010},
        '{IODI_INT_ACK, 6'h00, 16'h0, 1'b0, 16'h0}, '{IODI_CH_ADDR, 6'h00, 16'h0, 1'b1, WA},
        '{IODI_CH_IN, 6'h00, 16'h0, 1'b1, WD}, '{IODI_CH_IN, 6'h00, 16'h0, 1'b0, 16'h0},
        '{IODI_TEST, 6'h10, 16'h0, 1'b1, 16'h2}, '{IODI_TEST, 6'h10, 16'h0, 1'b0, 16'h1},
        '{IODI_TEST, 6'h11, 16'h0, 1'b1, 16'h0}, '{IODI_MASK, 6'h10, 16'hfffe, 1'b0, 16'h0},
        '{IODI_MASK, 6'h10, 16'h0001, 1'b0, 16'h1}};

    logic              sys_clk, rstn, cmd_valid, cmd_ready_q, rsp_valid_q;
    logic              rsp_busy_q, rsp_done_q, int_mask_q, read_pulse_q;
    logic              busy_flag, done_flag, int_pending, chan_grant;
    iodi_kind_t        cmd_kind;
    logic [CODE_W-1:0] cmd_code;
    logic [DATA_W-1:0] cmd_wdata, rsp_data_q;
    logic [1:0]        read_which_q;
    int                fail_count, checks_done, cyc, pulse_cnt;

    // ========================================
    // The two ends, joined by the shared bus
    iodi_if bus_if ();
    iodi_ctrl #(.DEV_CODE(6'h10), .MASK_BIT(0)) iodi_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn),
        .bus(bus_if.dev), .reg_first(W1), .reg_second(W2), .reg_third(W3), .busy_flag(busy_flag),
        .done_flag(done_flag), .int_pending(int_pending), .chan_grant(chan_grant), .chan_addr(WA),
        .chan_data(WD), .int_mask_q(int_mask_q), .read_pulse_q(read_pulse_q), .read_which_q(read_which_q));
    iodi_cpu iodi_cpu_inst (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_if.cpu), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready_q(cmd_ready_q),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .rsp_busy_q(rsp_busy_q), .rsp_done_q(rsp_done_q));
    iodi_monitor #(.DEV_CODE(6'h10)) iodi_monitor_inst (.sys_clk(sys_clk), .rstn(rstn),
        .data_cpu_oe(bus_if.data_cpu_oe), .data_from_dev(bus_if.data_from_dev),
        .data_dev_oe(bus_if.data_dev_oe), .device_select_code(bus_if.device_select_code),
        .read_strobe_first(bus_if.read_strobe_first), .read_strobe_second(bus_if.read_strobe_second),
        .read_strobe_third(bus_if.read_strobe_third), .mask_load_strobe(bus_if.mask_load_strobe),
        .interrupt_ack_cycle(bus_if.interrupt_ack_cycle), .channel_address_cycle(bus_if.channel_address_cycle),
        .channel_input_cycle(bus_if.channel_input_cycle), .busy_pull(bus_if.busy_pull),
        .done_pull(bus_if.done_pull));

    // Free-running clock of 8 ns.
    always #4 sys_clk = ~sys_clk;

    // Counts clock cycles and data-in pulses; a hang ends the run as a failure.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (read_pulse_q === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
        end
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ========================================
    // Shared tasks
    // Compares one value and counts the result.
    task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Waits until the processor end is idle, then offers one command for one edge.
    task automatic issue(input iodi_row_t r);
        int n;
        n = 0;
        @(posedge sys_clk);
        while (cmd_ready_q !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        cmd_valid   <= 1'b1;
        cmd_kind    <= r.kind;
        cmd_code    <= r.code;
        cmd_wdata   <= r.wdata;
        busy_flag   <= r.en;
        done_flag   <= !r.en;
        int_pending <= r.en;
        chan_grant  <= r.en;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask : issue

    // Issues a command and waits, bounded, for its one-cycle response.
    task automatic run(input iodi_row_t r);
        int n;
        n = 0;
        issue(r);
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (rsp_valid_q !== 1'b1 && n < 200);
        if (n >= 200) begin
            fail_count++;
        end
    endtask : run

    // Prints the verdict and stops.
    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // ========================================
    // Main sequence
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = IODI_RD_FIRST;
        cmd_code = 6'h00;
        cmd_wdata = 16'h0;
        {busy_flag, done_flag, int_pending, chan_grant} = 4'h0;
        {fail_count, checks_done, cyc, pulse_cnt} = '0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        // Every kind of operation, answered or refused, from the table.
        for (int i = 0; i < 15; i++) begin
            run(ROWS[i]);
            case (ROWS[i].kind)
                IODI_TEST: chk("test flags", {14'h0, rsp_busy_q, rsp_done_q}, ROWS[i].exp);
                IODI_MASK: chk("mask bit", {15'h0, int_mask_q}, ROWS[i].exp);
                default:   chk("read word", rsp_data_q, ROWS[i].exp);
            endcase
            if (ROWS[i].exp != 16'h0 && ROWS[i].kind <= IODI_RD_THIRD) begin
                chk("which strobe", {14'h0, read_which_q}, {14'h0, ROWS[i].kind[1:0]});
            end
        end
        chk("pulse count", pulse_cnt[15:0], 16'h0003);
        // Reset in the middle of a data-in strobe drops every driver at once.
        issue(ROWS[1]);
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("oe in reset", {15'h0, bus_if.data_dev_oe}, 16'h0);
        chk("strobe in reset", {15'h0, bus_if.read_strobe_second}, 16'h0);
        chk("mask in reset", {15'h0, int_mask_q}, 16'h0);
        @(posedge sys_clk);
        rstn <= 1'b1;
        run(ROWS[2]);
        chk("read after reset", rsp_data_q, W3);
        wrap_up();
    end

endmodule : io_bus_data_in_port_tb_top

`default_nettype wire

/* File: test/iodi_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module iodi_monitor #(
    parameter logic [5:0] DEV_CODE = 6'h10  // Code of the watched controller.
) (
    input wire logic                        sys_clk,
    input wire logic                        rstn,
    input wire logic                        data_cpu_oe,
    input wire logic [iodi_pkg::DATA_W-1:0] data_from_dev,
    input wire logic                        data_dev_oe,
    input wire logic [iodi_pkg::CODE_W-1:0] device_select_code,
    input wire logic                        read_strobe_first,
    input wire logic                        read_strobe_second,
    input wire logic                        read_strobe_third,
    input wire logic                        mask_load_strobe,
    input wire logic                        interrupt_ack_cycle,
    input wire logic                        channel_address_cycle,
    input wire logic                        channel_input_cycle,
    input wire logic                        busy_pull,
    input wire logic                        done_pull
);
    import iodi_pkg::*;

    // ========================================
    // Decode of the cycles in which the controller may source data
    logic match_w;  // Select lines carry our code.
    logic rd_w;     // Some data-in strobe is up.
    logic oth_w;    // Acknowledge or channel cycle is up.
    logic src_w;    // A cycle in which driving is allowed.
    assign match_w = (device_select_code == DEV_CODE);
    assign rd_w    = read_strobe_first | read_strobe_second | read_strobe_third;
    assign oth_w   = interrupt_ack_cycle | channel_address_cycle | channel_input_cycle;
    assign src_w   = (match_w & rd_w) | oth_w;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ========================================
    // Checks on the controller's drivers and test lines
    first_drive_a: assert property (match_w && read_strobe_first |=> data_dev_oe)
        else $error("first register not driven");
    second_drive_a: assert property (match_w && read_strobe_second |=> data_dev_oe)
        else $error("second register not driven");
    third_drive_a: assert property (match_w && read_strobe_third |=> data_dev_oe)
        else $error("third register not driven");
    oe_release_a: assert property (!src_w |=> !data_dev_oe)
        else $error("data lines driven outside a source cycle");
    strobe_qual_a: assert property (rd_w && !match_w && !oth_w |=> !data_dev_oe)
        else $error("strobe answered without a code match");
    bus_owner_a: assert property (!(data_cpu_oe && data_dev_oe))
        else $error("both sides drive the data lines");
    ack_word_a: assert property (interrupt_ack_cycle && $past(interrupt_ack_cycle) && data_dev_oe
        |-> data_from_dev == {{(DATA_W-CODE_W){1'b0}}, DEV_CODE}) else $error("wrong acknowledge word");
    busy_pull_a: assert property (busy_pull |-> $past(match_w))
        else $error("busy pulled while not selected");
    done_pull_a: assert property (done_pull |-> $past(match_w))
        else $error("done pulled while not selected");

    // Main scenarios seen at least once.
    cover property (match_w && read_strobe_third ##1 data_dev_oe);
    cover property (interrupt_ack_cycle && data_dev_oe);
    cover property (mask_load_strobe && data_cpu_oe);
    cover property (busy_pull);

endmodule : iodi_monitor

`default_nettype wire
